// File: core/qprm_pkg.sv
// shared constants and types for the queue-to-port routing register bank
package qprm_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;

	// printed register indices; the byte address is four times the index
	localparam logic [11:0] IDX_SLAVE_EN_HIGH = 12'h16C;
	localparam logic [11:0] IDX_SLAVE_EN_LOW = 12'h16E;
	localparam logic [11:0] IDX_SEL_TOP = 12'h178;
	localparam logic [11:0] IDX_SEL_THIRD = 12'h17A;
	localparam logic [11:0] IDX_MODE = 12'h180;
	localparam logic [11:0] IDX_STATUS = 12'h182;

	localparam logic [11:0] ADDR_SLAVE_EN_HIGH = {IDX_SLAVE_EN_HIGH[9:0], 2'b00};
	localparam logic [11:0] ADDR_SLAVE_EN_LOW = {IDX_SLAVE_EN_LOW[9:0], 2'b00};
	localparam logic [11:0] ADDR_SEL_TOP = {IDX_SEL_TOP[9:0], 2'b00};
	localparam logic [11:0] ADDR_SEL_THIRD = {IDX_SEL_THIRD[9:0], 2'b00};
	localparam logic [11:0] ADDR_MODE = {IDX_MODE[9:0], 2'b00};
	localparam logic [11:0] ADDR_STATUS = {IDX_STATUS[9:0], 2'b00};

	// reset values
	localparam logic [15:0] RST_SLAVE_EN = 16'h0000;
	localparam logic [15:0] RST_SELECT = 16'h0000;
	localparam logic [1:0] RST_MODE = 2'h0;

	// mode register fields
	localparam int MODE_SHARED_BIT = 0;
	localparam int MODE_PORTS32_BIT = 1;
	// status register fields
	localparam int STAT_COUNT_LSB = 0;
	localparam int STAT_SHARED_BIT = 8;
	localparam int STAT_PORTS32_BIT = 9;

	// queue geometry
	localparam int NUM_QUEUES = 64;
	localparam int SHARED_QUEUES = 32;
	localparam int QUEUES_PER_GROUP = 4;
	localparam int UPPER_FIRST_QUEUE = 32;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef logic [4:0] port_num_t;

	typedef enum logic [1:0] {WR_IDLE = 2'h1, WR_RESP = 2'h2} wr_state_e;
	typedef enum logic [1:0] {RD_IDLE = 2'h1, RD_DATA = 2'h2} rd_state_e;

	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} axi_rsp_s;

endpackage : qprm_pkg

// File: core/queue_route_lookup.sv
// registered queue-to-port lookup for a contiguous run of queues
`timescale 1ns/1ps
module queue_route_lookup
	import qprm_pkg::*;
#(
	parameter int FIRST_QUEUE = UPPER_FIRST_QUEUE,
	parameter int NUM_Q = 32
)
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [NUM_Q-1:0] sel_bits,
	input wire logic route_active,
	output port_num_t [NUM_Q-1:0] port_map
);

	if ((FIRST_QUEUE % QUEUES_PER_GROUP) != 0 || FIRST_QUEUE + NUM_Q > NUM_QUEUES
		|| (NUM_Q % QUEUES_PER_GROUP) != 0)
	begin : g_bad
		$error("queue_route_lookup: queue range not group aligned");
	end

	typedef struct packed {
		port_num_t [NUM_Q-1:0] map;
	} look_state_s;

	// reset shows every queue on the even port of its pair, as select bits of zero would
	function automatic look_state_s reset_map();
		look_state_s res;
		res = '0;
		for (int i = 0; i < NUM_Q; i++)
			res.map[i] = port_num_t'(2 * ((FIRST_QUEUE + i) / QUEUES_PER_GROUP));
		return res;
	endfunction : reset_map

	localparam look_state_s RST_LOOK = reset_map();

	look_state_s s_r;
	look_state_s s_nxt;
	port_num_t [NUM_Q-1:0] map_c;

	for (genvar i = 0; i < NUM_Q; i++)
	begin : g_q
		localparam int GROUP = (FIRST_QUEUE + i) / QUEUES_PER_GROUP;
		// group n serves only ports 2n and 2n+1; a set select bit picks odd while route_active is high
		assign map_c[i] = port_num_t'(2 * GROUP) + {4'h0, sel_bits[i] & route_active};
	end

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.map = map_c;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			s_r <= RST_LOOK;
		else
			s_r <= s_nxt;
	end

	assign port_map = s_r.map;

	group_pair_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_r.map[NUM_Q-1][4:1] == 4'((FIRST_QUEUE + NUM_Q - 1) / QUEUES_PER_GROUP)
		&& s_r.map[0][4:1] == 4'(FIRST_QUEUE / QUEUES_PER_GROUP))
		else $error("queue mapped outside its port pair");

endmodule : queue_route_lookup

// File: core/queue_port_route_map.sv
// AXI4-Lite register bank for slave queue enables and upper queue port routing
`timescale 1ns/1ps
module queue_port_route_map
	import qprm_pkg::*;
#(
	parameter int SLAVE_QUEUES = SHARED_QUEUES,
	parameter int UPPER_QUEUES = 32
)
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire axi_req_s axi_req,
	output axi_rsp_s axi_rsp,
	output logic [SLAVE_QUEUES-1:0] slave_q_en,
	output logic upper_route_active,
	output port_num_t [UPPER_QUEUES-1:0] port_map
);

	if (SLAVE_QUEUES != 2 * REG_W || UPPER_QUEUES != 2 * REG_W)
	begin : g_bad
		$error("queue_port_route_map: map widths must be two registers");
	end

	typedef struct packed {
		wr_state_e wst;
		logic aw_got;
		logic w_got;
		logic [ADDR_W-1:0] aw_addr;
		logic [DATA_W-1:0] w_data;
		logic [3:0] w_strb;
		logic [1:0] bresp;
		rd_state_e rst;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
		logic [REG_W-1:0] en_low;
		logic [REG_W-1:0] en_high;
		logic [REG_W-1:0] sel_third;
		logic [REG_W-1:0] sel_top;
		logic [1:0] mode;
		logic [SLAVE_QUEUES-1:0] en_out;
	} bank_state_s;

	localparam bank_state_s RST_STATE = '{
		wst: WR_IDLE, aw_got: 1'b0, w_got: 1'b0, aw_addr: '0, w_data: '0, w_strb: '0,
		bresp: RESP_OKAY, rst: RD_IDLE, rdata: '0, rresp: RESP_OKAY,
		en_low: RST_SLAVE_EN, en_high: RST_SLAVE_EN, sel_third: RST_SELECT,
		sel_top: RST_SELECT, mode: RST_MODE, en_out: '0};

	bank_state_s s_r;
	bank_state_s s_nxt;

	logic aw_rdy;
	logic w_rdy;
	logic aw_hs;
	logic w_hs;
	logic wr_do;
	logic [ADDR_W-1:0] wr_addr_c;
	logic [DATA_W-1:0] wr_data_c;
	logic [3:0] wr_strb_c;
	logic shared_on;
	logic ports32_on;
	logic [5:0] en_count;

	// only the two low byte lanes carry register bits; upper lanes are dropped
	function automatic logic [REG_W-1:0] merge16(
		input logic [REG_W-1:0] old,
		input logic [DATA_W-1:0] data,
		input logic [3:0] strb
	);
		logic [REG_W-1:0] res;
		res = old;
		if (strb[0])
			res[7:0] = data[7:0];
		if (strb[1])
			res[15:8] = data[15:8];
		return res;
	endfunction : merge16

	assign shared_on = s_r.mode[MODE_SHARED_BIT];
	assign ports32_on = s_r.mode[MODE_PORTS32_BIT];
	assign aw_rdy = (s_r.wst == WR_IDLE) && !s_r.aw_got;
	assign w_rdy = (s_r.wst == WR_IDLE) && !s_r.w_got;
	assign aw_hs = axi_req.awvalid && aw_rdy;
	assign w_hs = axi_req.wvalid && w_rdy;
	assign wr_addr_c = s_r.aw_got ? s_r.aw_addr : axi_req.awaddr;
	assign wr_data_c = s_r.w_got ? s_r.w_data : axi_req.wdata;
	assign wr_strb_c = s_r.w_got ? s_r.w_strb : axi_req.wstrb;
	// address and data may arrive in either order or together
	assign wr_do = (s_r.wst == WR_IDLE) && (s_r.aw_got || aw_hs) && (s_r.w_got || w_hs);

	always_comb
	begin
		en_count = '0;
		for (int i = 0; i < SLAVE_QUEUES; i++)
			en_count = en_count + {5'h00, s_r.en_out[i]};
	end

	always_comb
	begin
		s_nxt = s_r;
		if (aw_hs)
		begin
			s_nxt.aw_got = 1'b1;
			s_nxt.aw_addr = axi_req.awaddr;
		end
		if (w_hs)
		begin
			s_nxt.w_got = 1'b1;
			s_nxt.w_data = axi_req.wdata;
			s_nxt.w_strb = axi_req.wstrb;
		end
		case (s_r.wst)
			WR_IDLE:
			begin
				if (wr_do)
				begin
					s_nxt.aw_got = 1'b0;
					s_nxt.w_got = 1'b0;
					s_nxt.wst = WR_RESP;
					s_nxt.bresp = RESP_OKAY;
					case (wr_addr_c)
						ADDR_SLAVE_EN_LOW:
							s_nxt.en_low = merge16(s_r.en_low, wr_data_c, wr_strb_c);
						ADDR_SLAVE_EN_HIGH:
							s_nxt.en_high = merge16(s_r.en_high, wr_data_c, wr_strb_c);
						ADDR_SEL_TOP:
							s_nxt.sel_top = merge16(s_r.sel_top, wr_data_c, wr_strb_c);
						ADDR_SEL_THIRD:
							s_nxt.sel_third = merge16(s_r.sel_third, wr_data_c, wr_strb_c);
						ADDR_MODE:
						begin
							if (wr_strb_c[0])
								s_nxt.mode = wr_data_c[1:0];
						end
						ADDR_STATUS:
							s_nxt.bresp = RESP_OKAY;
						default:
							s_nxt.bresp = RESP_SLVERR;
					endcase
				end
			end
			WR_RESP:
			begin
				if (axi_req.bready)
					s_nxt.wst = WR_IDLE;
			end
			default:
				s_nxt.wst = WR_IDLE;
		endcase

		case (s_r.rst)
			RD_IDLE:
			begin
				if (axi_req.arvalid)
				begin
					s_nxt.rst = RD_DATA;
					s_nxt.rresp = RESP_OKAY;
					s_nxt.rdata = '0;
					case (axi_req.araddr)
						ADDR_SLAVE_EN_LOW:
							s_nxt.rdata[15:0] = s_r.en_low;
						ADDR_SLAVE_EN_HIGH:
							s_nxt.rdata[15:0] = s_r.en_high;
						ADDR_SEL_TOP:
							s_nxt.rdata[15:0] = s_r.sel_top;
						ADDR_SEL_THIRD:
							s_nxt.rdata[15:0] = s_r.sel_third;
						ADDR_MODE:
							s_nxt.rdata[1:0] = s_r.mode;
						ADDR_STATUS:
						begin
							s_nxt.rdata[STAT_COUNT_LSB +: 6] = en_count;
							s_nxt.rdata[STAT_SHARED_BIT] = shared_on;
							s_nxt.rdata[STAT_PORTS32_BIT] = ports32_on;
						end
						default:
							s_nxt.rresp = RESP_SLVERR;
					endcase
				end
			end
			RD_DATA:
			begin
				if (axi_req.rready)
					s_nxt.rst = RD_IDLE;
			end
			default:
				s_nxt.rst = RD_IDLE;
		endcase

		// enables mean nothing outside shared mode, so they are withheld there
		s_nxt.en_out = shared_on ? {s_r.en_high, s_r.en_low} : '0;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			s_r <= RST_STATE;
		else
			s_r <= s_nxt;
	end

	always_comb
	begin
		axi_rsp = '0;
		axi_rsp.awready = aw_rdy;
		axi_rsp.wready = w_rdy;
		axi_rsp.bvalid = (s_r.wst == WR_RESP);
		axi_rsp.bresp = s_r.bresp;
		axi_rsp.arready = (s_r.rst == RD_IDLE);
		axi_rsp.rvalid = (s_r.rst == RD_DATA);
		axi_rsp.rdata = s_r.rdata;
		axi_rsp.rresp = s_r.rresp;
	end

	assign slave_q_en = s_r.en_out;
	assign upper_route_active = ports32_on;

	queue_route_lookup #(
		.FIRST_QUEUE(UPPER_FIRST_QUEUE),
		.NUM_Q(UPPER_QUEUES)
	) u_lookup (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.sel_bits({s_r.sel_top, s_r.sel_third}),
		.route_active(ports32_on),
		.port_map(port_map)
	);

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	slave_low_map_a: assert property (
		wr_do && wr_addr_c == ADDR_SLAVE_EN_LOW && wr_strb_c[1:0] == 2'h3 && shared_on
		|=> ##1 slave_q_en[15:0] == $past(wr_data_c[15:0], 2))
		else $error("low slave enable not reflected");

	slave_high_map_a: assert property (
		wr_do && wr_addr_c == ADDR_SLAVE_EN_HIGH && wr_strb_c[1:0] == 2'h3 && shared_on
		|=> ##1 slave_q_en[31:16] == $past(wr_data_c[15:0], 2))
		else $error("high slave enable not reflected");

	shared_gate_a: assert property (
		!shared_on |=> slave_q_en == '0)
		else $error("slave enables shown outside shared mode");

	enable_meaning_a: assert property (
		shared_on && s_r.en_low[3] |=> slave_q_en[3])
		else $error("set enable bit not marked enabled");

	top_route_a: assert property (
		wr_do && wr_addr_c == ADDR_SEL_TOP && wr_strb_c[1] && ports32_on
		|=> ##1 port_map[31] == 5'h1E + {4'h0, $past(wr_data_c[15], 2)})
		else $error("queue 63 routed wrongly");

	third_route_a: assert property (
		wr_do && wr_addr_c == ADDR_SEL_THIRD && wr_strb_c[0] && ports32_on
		|=> ##1 port_map[0] == 5'h10 + {4'h0, $past(wr_data_c[0], 2)})
		else $error("queue 32 routed wrongly");

	ports32_gate_a: assert property (
		!ports32_on |=> port_map[1] == 5'h10 && port_map[31] == 5'h1E)
		else $error("select bits used outside 32-port mode");

	odd_select_a: assert property (
		ports32_on && s_r.sel_third[5] |=> port_map[5][0] && port_map[5][4:1] == 4'h9)
		else $error("select one did not pick odd port");

	route_follow_a: assert property (
		ports32_on |=> port_map[16] == 5'h18 + {4'h0, $past(s_r.sel_top[0])})
		else $error("port map not re-evaluated");

	bresp_hold_a: assert property (
		axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
		else $error("write response dropped early");

	rdata_hold_a: assert property (
		axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
		else $error("read data dropped early");

	wr_answer_a: assert property (
		wr_do |=> axi_rsp.bvalid && !axi_rsp.awready && !axi_rsp.wready)
		else $error("write not answered next cycle");

	rd_answer_a: assert property (
		axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready)
		else $error("read not answered next cycle");

	status_ro_a: assert property (
		wr_do && wr_addr_c == ADDR_STATUS |=> axi_rsp.bresp == RESP_OKAY && $stable(s_r.mode))
		else $error("status write had an effect");

	wr_together_c: cover property (axi_req.awvalid && axi_req.wvalid && aw_rdy && w_rdy);
	wr_addr_first_c: cover property (s_r.aw_got && !s_r.w_got ##1 wr_do);
	rd_top_c: cover property (
		axi_req.arvalid && axi_rsp.arready && axi_req.araddr == ADDR_SEL_TOP);
	normal_pattern_c: cover property (ports32_on && s_r.sel_top == 16'hAAAA);
	wr_error_c: cover property (wr_do && s_nxt.bresp == RESP_SLVERR);

endmodule : queue_port_route_map

// File: tb/tb_queue_port_route_map.sv
// self-checking bench for the queue-to-port routing register bank
`timescale 1ns/1ps
module tb_queue_port_route_map;
	import qprm_pkg::*;

	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	axi_req_s axi_req = '0;
	axi_rsp_s axi_rsp;
	logic [31:0] slave_q_en;
	logic upper_route_active;
	port_num_t [31:0] port_map;
	int errors = 0;
	int checks = 0;
	int cyc = 0;
	logic [1:0] wr_q[$];
	logic [33:0] rd_q[$];
	logic [15:0] en_lo;
	logic [15:0] en_hi;
	logic [15:0] s_top;
	logic [15:0] s_third;
	logic [11:0] regs[6];

	queue_port_route_map dut (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.axi_req(axi_req),
		.axi_rsp(axi_rsp),
		.slave_q_en(slave_q_en),
		.upper_route_active(upper_route_active),
		.port_map(port_map)
	);

	always #5 ref_clk = ~ref_clk;

	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	task automatic check(input logic [159:0] got, input logic [159:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask : check

	// responses are judged where they appear, against the oldest note
	always @(posedge ref_clk)
	begin
		if (rst_b && axi_rsp.bvalid && axi_req.bready)
			check(160'(axi_rsp.bresp), 160'(wr_q.pop_front()), "write response");
		if (rst_b && axi_rsp.rvalid && axi_req.rready)
			check(160'({axi_rsp.rresp, axi_rsp.rdata}), 160'(rd_q.pop_front()), "read data");
	end

	// the whole run needs well under two hundred cycles
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			print_verdict();
		end
	end

	// readies are combinational, so sample them at the falling edge before the taking edge
	task automatic axi_write(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s,
		input logic [1:0] resp);
		logic ta;
		logic tw;
		logic tb;
		logic aw_done;
		logic w_done;
		wr_q.push_back(resp);
		axi_req.awvalid <= 1'b1;
		axi_req.awaddr <= a;
		axi_req.wvalid <= 1'b1;
		axi_req.wdata <= {16'($urandom()), d};
		axi_req.wstrb <= s;
		aw_done = 1'b0;
		w_done = 1'b0;
		tb = 1'b0;
		while (!tb)
		begin
			@(negedge ref_clk);
			ta = axi_req.awvalid & axi_rsp.awready;
			tw = axi_req.wvalid & axi_rsp.wready;
			tb = axi_rsp.bvalid & axi_req.bready;
			@(posedge ref_clk);
			if (ta)
				axi_req.awvalid <= 1'b0;
			if (tw)
				axi_req.wvalid <= 1'b0;
			aw_done = aw_done | ta;
			w_done = w_done | tw;
			if (tb)
				axi_req.bready <= 1'b0;
			else if (aw_done && w_done)
				axi_req.bready <= 1'b1;
		end
	endtask : axi_write

	task automatic axi_read(input logic [11:0] a, input logic [31:0] d, input logic [1:0] resp);
		logic ta;
		logic tr;
		rd_q.push_back({resp, d});
		axi_req.arvalid <= 1'b1;
		axi_req.araddr <= a;
		tr = 1'b0;
		while (!tr)
		begin
			@(negedge ref_clk);
			ta = axi_req.arvalid & axi_rsp.arready;
			tr = axi_rsp.rvalid & axi_req.rready;
			@(posedge ref_clk);
			if (ta)
			begin
				axi_req.arvalid <= 1'b0;
				axi_req.rready <= 1'b1;
			end
			if (tr)
				axi_req.rready <= 1'b0;
		end
	endtask : axi_read

	task automatic check_map(input logic p32);
		port_num_t [31:0] exp;
		logic [31:0] sel;
		sel = {s_top, s_third};
		for (int i = 0; i < 32; i++)
			exp[i] = port_num_t'(2 * ((32 + i) / 4) + int'(sel[i] & p32));
		repeat (3) @(posedge ref_clk);
		check(160'(port_map), 160'(exp), "port map");
		check(160'(upper_route_active), 160'(p32), "route active");
	endtask : check_map

	initial
	begin
		void'($urandom(32'hA0D2));
		regs = '{ADDR_SLAVE_EN_HIGH, ADDR_SLAVE_EN_LOW, ADDR_SEL_TOP, ADDR_SEL_THIRD,
			ADDR_MODE, ADDR_STATUS};
		repeat (10) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		s_top = 16'h0000;
		s_third = 16'h0000;
		check_map(1'b0);
		check(160'(slave_q_en), 160'h0, "enables after reset");
		for (int i = 0; i < 6; i++)
			axi_read(regs[i], 32'h0000_0000, RESP_OKAY);
		en_lo = 16'($urandom());
		en_hi = 16'($urandom());
		axi_write(ADDR_SLAVE_EN_LOW, en_lo, 4'hF, RESP_OKAY);
		axi_write(ADDR_SLAVE_EN_HIGH, en_hi, 4'hF, RESP_OKAY);
		axi_read(ADDR_SLAVE_EN_LOW, 32'(en_lo), RESP_OKAY);
		axi_read(ADDR_SLAVE_EN_HIGH, 32'(en_hi), RESP_OKAY);
		repeat (3) @(posedge ref_clk);
		check(160'(slave_q_en), 160'h0, "enables outside shared mode");
		axi_write(ADDR_MODE, 16'h0001, 4'h1, RESP_OKAY);
		repeat (3) @(posedge ref_clk);
		check(160'(slave_q_en), 160'({en_hi, en_lo}), "enables in shared mode");
		axi_read(ADDR_STATUS, 32'h100 | 32'($countones({en_hi, en_lo})), RESP_OKAY);
		// status is read-only: the write is accepted and has no effect
		axi_write(ADDR_STATUS, 16'hFFFF, 4'hF, RESP_OKAY);
		axi_read(ADDR_STATUS, 32'h100 | 32'($countones({en_hi, en_lo})), RESP_OKAY);
		en_lo = 16'($urandom());
		en_hi = 16'($urandom());
		axi_write(ADDR_SLAVE_EN_LOW, en_lo, 4'hF, RESP_OKAY);
		axi_write(ADDR_SLAVE_EN_HIGH, en_hi, 4'hF, RESP_OKAY);
		repeat (3) @(posedge ref_clk);
		check(160'(slave_q_en), 160'({en_hi, en_lo}), "enables rewritten in shared mode");
		axi_write(ADDR_SLAVE_EN_LOW, 16'hFFFF, 4'h1, RESP_OKAY);
		axi_write(ADDR_SLAVE_EN_LOW, 16'h0000, 4'h2, RESP_OKAY);
		en_lo = 16'h00FF;
		axi_read(ADDR_SLAVE_EN_LOW, 32'(en_lo), RESP_OKAY);
		axi_write(12'h004, 16'h5555, 4'hF, RESP_SLVERR);
		axi_write(ADDR_SEL_TOP + 12'h001, 16'h5555, 4'hF, RESP_SLVERR);
		axi_read(12'h004, 32'h0000_0000, RESP_SLVERR);
		for (int k = 0; k < 3; k++)
		begin
			// first pass uses the alternating pattern of normal 32-port operation
			s_top = (k == 0) ? 16'hAAAA : 16'($urandom());
			s_third = (k == 0) ? 16'hAAAA : 16'($urandom());
			axi_write(ADDR_SEL_TOP, s_top, 4'hF, RESP_OKAY);
			axi_write(ADDR_SEL_THIRD, s_third, 4'hF, RESP_OKAY);
			axi_read(ADDR_SEL_TOP, 32'(s_top), RESP_OKAY);
			axi_read(ADDR_SEL_THIRD, 32'(s_third), RESP_OKAY);
			axi_write(ADDR_MODE, 16'h0001, 4'h1, RESP_OKAY);
			check_map(1'b0);
			axi_write(ADDR_MODE, 16'h0003, 4'h1, RESP_OKAY);
			check_map(1'b1);
			axi_read(ADDR_MODE, 32'h0000_0003, RESP_OKAY);
		end
		repeat (3) @(posedge ref_clk);
		print_verdict();
	end

endmodule : tb_queue_port_route_map
